//--- src/ueit_top.v
// iso in responder, out bank manager and out dma channel, wishbone slave
// How it works
// - iso in, nothing ready: flow error, no reply only on single transaction endpoints
// - iso in ignores forced stall entirely
// - first in token answered with matching pid
// - missed later tokens flush banks, flush error
// - first token without bank: data0 zlp
// - second of three without bank: data1 zlp
// - last transaction without bank: data0 zlp
// - microframe without tokens: no flush, no error
// - too few banks validated: transaction error
// - auto mode zlp clears rx ready itself
// - auto mode all banks full: busy flag
// - buffer end truncates the out packet
// - remaining count zero raises buffer end event
// - short packet ends dma transfer when enabled
// - short end event after final packet moved
// - channel runs, stops when buffer exhausted
// - bank freed once all bytes read
// - zlp to free endpoint: ack, count zero
//
// The Wishbone slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ueit_defines.vh"
module ueit_top (
	input  wire        clk_i,      // system clock
	input  wire        rst_i,      // sync reset, high
	input  wire        wb_cyc_i,   // wishbone cycle
	input  wire        wb_stb_i,   // wishbone strobe
	input  wire        wb_we_i,    // wishbone write
	input  wire [7:0]  wb_adr_i,   // byte address
	input  wire [3:0]  wb_sel_i,   // byte enables
	input  wire [31:0] wb_dat_i,   // write data
	output reg  [31:0] wb_dat_o,   // read data
	output reg         wb_ack_o,   // acknowledge
	input  wire        sof_i,      // microframe start pulse
	input  wire        in_tok_i,   // valid in token pulse
	input  wire        rx_pkt_i,   // out packet received pulse
	input  wire [10:0] rx_len_i,   // out packet length
	output reg         tx_resp_o,  // send data packet pulse
	output reg  [1:0]  tx_pid_o,   // data pid number
	output reg         tx_zlp_o,   // packet is zero length
	output reg         stall_o,    // send stall pulse
	output reg         rx_ack_o,   // ack out packet pulse
	output reg         rx_nak_o,   // nak out packet pulse
	output reg         ep_irq_o,   // endpoint interrupt
	output reg         dma_irq_o   // dma channel interrupt
);
	function [31:0] bmask;
		input [3:0] s;
		bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction
	function [1:0] min2;
		input [1:0] a;
		input [1:0] b;
		min2 = (a < b) ? a : b;
	endfunction
	function [2:0] min4;
		input [15:0] a;
		input [15:0] b;
		reg   [15:0] m;
		begin
			m = (a < b) ? a : b;
			min4 = (m > 16'h0004) ? 3'h4 : m[2:0];
		end
	endfunction
	function [1:0] bump;
		input [1:0] p;
		input [1:0] n;
		bump = (p + 2'h1 >= n) ? 2'h0 : p + 2'h1;
	endfunction

	reg  [31:0] cfg_q, cfg_d;
	reg  [5:0]  ien_q, ien_d;
	reg  [5:0]  flg_q, flg_d;
	reg  [1:0]  txb_q, txb_d, tok_q, tok_d;
	reg  [1:0]  vcnt_q, vcnt_d, wp_q, wp_d;
	reg  [1:0]  rp_q, rp_d, busy_q, busy_d;
	reg         sent_q, sent_d, zlpf_q, zlpf_d;
	reg  [10:0] bcnt_q [0:2];
	reg  [10:0] bcnt_d [0:2];
	reg  [2:0]  bshort_q, bshort_d, n;
	reg  [10:0] bytec_q, bytec_d, left;
	reg  [4:0]  dct_q, dct_d;
	reg  [15:0] blen_q, blen_d, rem_q, rem_d;
	reg  [2:1]  dst_q, dst_d;
	reg  [31:0] dat_d;
	reg         run_q, run_d, dma_mv, freeb, hclr;
	reg         resp_d, zlp_d, stall_d, ack_d, nak_d;
	reg  [1:0]  pid_d, fl;
	reg  [5:0]  setf, clrf;
	integer     i, j;

	wire        req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        wr    = req & wb_we_i;
	wire        rd    = req & ~wb_we_i;
	wire [31:0] m     = bmask(wb_sel_i);
	wire [1:0]  nb    = (cfg_q[`UEIT_C_NB] == 2'h0) ? 2'h1
	                    : cfg_q[`UEIT_C_NB];
	wire [1:0]  rxb   = (cfg_q[`UEIT_C_RXB] == 2'h0) ? 2'h1
	                    : cfg_q[`UEIT_C_RXB];
	wire        iso   = cfg_q[`UEIT_C_ISO];
	wire        autov = cfg_q[`UEIT_C_AUTO];
	wire        fstl  = cfg_q[`UEIT_C_STALL];
	wire [10:0] maxp  = cfg_q[`UEIT_C_MAXP];
	wire [10:0] head  = bcnt_q[rp_q];
	wire        hbusy = (busy_q != 2'h0);

	always @*
	begin
		cfg_d = cfg_q;
		ien_d = ien_q;
		txb_d = txb_q;
		tok_d = tok_q;
		vcnt_d = vcnt_q;
		sent_d = sent_q;
		zlpf_d = zlpf_q;
		for (i = 0; i < 3; i = i + 1)
			bcnt_d[i] = bcnt_q[i];
		bshort_d = bshort_q;
		wp_d = wp_q;
		rp_d = rp_q;
		busy_d = busy_q;
		bytec_d = bytec_q;
		dct_d = dct_q;
		blen_d = blen_q;
		rem_d = rem_q;
		run_d = run_q;
		dst_d = dst_q;
		resp_d = 1'b0;
		zlp_d = 1'b0;
		stall_d = 1'b0;
		ack_d = 1'b0;
		nak_d = 1'b0;
		pid_d = tx_pid_o;
		setf = 6'h00;
		hclr = 1'b0;
		fl = 2'h0;
		n = 3'h0;
		left = head;
		dma_mv = 1'b0;
		freeb = 1'b0;
		clrf = (wr && wb_adr_i == `UEIT_A_STA) ? (wb_dat_i[5:0] & m[5:0])
		       : 6'h00;
		if (wr && wb_adr_i == `UEIT_A_CFG)
			cfg_d = (cfg_q & ~m) | (wb_dat_i & m);
		if (wr && wb_adr_i == `UEIT_A_IEN)
			ien_d = (ien_q & ~m[5:0]) | (wb_dat_i[5:0] & m[5:0]);
		// microframe boundary closes the previous one first
		if (sof_i)
		begin
			if (tok_q != 2'h0)
			begin
				fl = min2(txb_q, nb - tok_q);
				if (!zlpf_q && fl != 2'h0)
				begin
					txb_d = txb_q - fl;
					setf[`UEIT_F_FLU] = 1'b1;
				end
				if (sent_q && vcnt_q < nb)
					setf[`UEIT_F_TRE] = 1'b1;
			end
			tok_d = 2'h0;
			sent_d = 1'b0;
			zlpf_d = 1'b0;
			vcnt_d = txb_d;
		end
		if (wr && wb_adr_i == `UEIT_A_TXV && wb_sel_i[0] && wb_dat_i[0]
		    && txb_d != 2'h3)
		begin
			txb_d = txb_d + 2'h1;
			vcnt_d = vcnt_d + 2'h1;
		end
		if (in_tok_i)
		begin
			if (!iso)
			begin
				if (fstl)
				begin
					stall_d = 1'b1;
					setf[`UEIT_F_STL] = 1'b1;
				end
				else if (txb_d != 2'h0)
				begin
					resp_d = 1'b1;
					pid_d = `UEIT_PID_D0;
					txb_d = txb_d - 2'h1;
				end
			end
			else if (tok_d < nb)
			begin
				if (txb_d != 2'h0)
				begin
					resp_d = 1'b1;
					pid_d = nb - tok_d - 2'h1;
					txb_d = txb_d - 2'h1;
					sent_d = 1'b1;
				end
				else
				begin
					setf[`UEIT_F_IFE] = 1'b1;
					if (tok_d == 2'h0)
					begin
						zlpf_d = 1'b1;
						// single transaction endpoints stay silent
						if (nb != 2'h1)
						begin
							resp_d = 1'b1;
							zlp_d = 1'b1;
							pid_d = `UEIT_PID_D0;
						end
					end
					else
					begin
						resp_d = 1'b1;
						zlp_d = 1'b1;
						pid_d = nb - tok_d - 2'h1;
					end
				end
				tok_d = tok_d + 2'h1;
			end
		end
		// drain head bank: dma has priority over firmware reads
		if (run_q && hbusy && head != 11'h000)
		begin
			n = min4({5'h00, head}, rem_q);
			dma_mv = 1'b1;
		end
		else if (rd && wb_adr_i == `UEIT_A_DAT && hbusy)
			n = min4({5'h00, head}, 16'h0004);
		left = head - {8'h00, n};
		if (dma_mv)
		begin
			rem_d = rem_q - {13'h0000, n};
			if (rem_d == 16'h0000)
			begin
				run_d = 1'b0;
				dst_d[`UEIT_S_BEND] = 1'b1;
				if (dct_q[`UEIT_D_TRUNC])
					left = 11'h000;
			end
		end
		bcnt_d[rp_q] = left;
		if (n != 3'h0 && left == 11'h000)
		begin
			freeb = 1'b1;
			if (dma_mv && bshort_q[rp_q] && dct_q[`UEIT_D_SPE])
			begin
				run_d = 1'b0;
				dst_d[`UEIT_S_TEND] = 1'b1;
			end
		end
		// manual mode: clearing ready releases the bank
		if (!autov && hbusy && clrf[`UEIT_F_RXR])
			freeb = 1'b1;
		if (freeb)
		begin
			rp_d = bump(rp_q, rxb);
			busy_d = busy_q - 2'h1;
			hclr = autov;
		end
		if (rx_pkt_i)
		begin
			if (!iso && fstl)
			begin
				stall_d = 1'b1;
				setf[`UEIT_F_STL] = 1'b1;
			end
			else if (busy_d < rxb)
			begin
				ack_d = 1'b1;
				bytec_d = rx_len_i;
				if (rx_len_i == 11'h000 && autov)
				begin
					hclr = 1'b1;
					if (run_q && dct_q[`UEIT_D_SPE])
					begin
						run_d = 1'b0;
						dst_d[`UEIT_S_TEND] = 1'b1;
					end
				end
				else
				begin
					setf[`UEIT_F_RXR] = 1'b1;
					bcnt_d[wp_q] = rx_len_i;
					bshort_d[wp_q] = (rx_len_i < maxp);
					wp_d = bump(wp_q, rxb);
					busy_d = busy_d + 2'h1;
					if (autov && busy_d == rxb)
						setf[`UEIT_F_BSY] = 1'b1;
				end
			end
			else
			begin
				nak_d = 1'b1;
				if (iso)
					setf[`UEIT_F_IFE] = 1'b1;
			end
		end
		if (wr && wb_adr_i == `UEIT_A_DCT)
		begin
			dct_d = (dct_q & ~m[4:0]) | (wb_dat_i[4:0] & m[4:0]);
			if (wb_sel_i[3] && wb_sel_i[2])
				blen_d = wb_dat_i[`UEIT_D_LEN];
			run_d = dct_d[`UEIT_D_RUN] && blen_d != 16'h0000;
			if (run_d && !run_q)
				rem_d = blen_d;
		end
		if (wr && wb_adr_i == `UEIT_A_DST)
			dst_d = dst_q & ~(wb_dat_i[2:1] & m[2:1]) | (dst_d & ~dst_q);
		// hardware set wins over firmware clear
		flg_d = (flg_q & ~clrf) | setf;
		if (hclr && !setf[`UEIT_F_RXR])
			flg_d[`UEIT_F_RXR] = 1'b0;
		case (wb_adr_i)
			`UEIT_A_CFG: dat_d = cfg_q;
			`UEIT_A_IEN: dat_d = {26'h0, ien_q};
			`UEIT_A_STA: dat_d = {5'h00, bytec_q, 4'h0, busy_q, txb_q,
			                      2'h0, flg_q};
			`UEIT_A_DCT: dat_d = {blen_q, 11'h000, dct_q};
			`UEIT_A_DST: dat_d = {rem_q, 13'h0000, dst_q, run_q};
			default:     dat_d = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cfg_q <= `UEIT_CFG_RST;
			ien_q <= 6'h00;
			flg_q <= 6'h00;
			txb_q <= 2'h0;
			tok_q <= 2'h0;
			vcnt_q <= 2'h0;
			sent_q <= 1'b0;
			zlpf_q <= 1'b0;
			for (j = 0; j < 3; j = j + 1)
				bcnt_q[j] <= 11'h000;
			bshort_q <= 3'h0;
			wp_q <= 2'h0;
			rp_q <= 2'h0;
			busy_q <= 2'h0;
			bytec_q <= 11'h000;
			dct_q <= 5'h00;
			blen_q <= 16'h0000;
			rem_q <= 16'h0000;
			run_q <= 1'b0;
			dst_q <= 2'h0;
			wb_dat_o <= 32'h0000_0000;
			wb_ack_o <= 1'b0;
			tx_resp_o <= 1'b0;
			tx_pid_o <= 2'h0;
			tx_zlp_o <= 1'b0;
			stall_o <= 1'b0;
			rx_ack_o <= 1'b0;
			rx_nak_o <= 1'b0;
			ep_irq_o <= 1'b0;
			dma_irq_o <= 1'b0;
		end
		else
		begin
			cfg_q <= cfg_d;
			ien_q <= ien_d;
			flg_q <= flg_d;
			txb_q <= txb_d;
			tok_q <= tok_d;
			vcnt_q <= vcnt_d;
			sent_q <= sent_d;
			zlpf_q <= zlpf_d;
			for (j = 0; j < 3; j = j + 1)
				bcnt_q[j] <= bcnt_d[j];
			bshort_q <= bshort_d;
			wp_q <= wp_d;
			rp_q <= rp_d;
			busy_q <= busy_d;
			bytec_q <= bytec_d;
			dct_q <= dct_d;
			blen_q <= blen_d;
			rem_q <= rem_d;
			run_q <= run_d;
			dst_q <= dst_d;
			wb_dat_o <= rd ? dat_d : 32'h0000_0000;
			wb_ack_o <= req;
			tx_resp_o <= resp_d;
			tx_pid_o <= pid_d;
			tx_zlp_o <= zlp_d;
			stall_o <= stall_d;
			rx_ack_o <= ack_d;
			rx_nak_o <= nak_d;
			ep_irq_o <= |(flg_d & ien_d);
			dma_irq_o <= (dst_d[`UEIT_S_BEND] & dct_d[`UEIT_D_BEIE])
			             | (dst_d[`UEIT_S_TEND] & dct_d[`UEIT_D_TEIE]);
		end
	end
endmodule // ueit_top

//--- src/ueit_defines.vh
// register map, field positions and reset values of the endpoint block
`ifndef UEIT_DEFINES_VH
`define UEIT_DEFINES_VH
`define UEIT_A_CFG   8'h00
`define UEIT_A_IEN   8'h04
`define UEIT_A_STA   8'h08
`define UEIT_A_TXV   8'h0c
`define UEIT_A_DCT   8'h10
`define UEIT_A_DST   8'h14
`define UEIT_A_DAT   8'h18
`define UEIT_C_NB    1:0
`define UEIT_C_RXB   3:2
`define UEIT_C_ISO   4
`define UEIT_C_AUTO  5
`define UEIT_C_STALL 6
`define UEIT_C_MAXP  26:16
`define UEIT_CFG_RST 32'h0200_0005
`define UEIT_F_RXR   0
`define UEIT_F_IFE   1
`define UEIT_F_FLU   2
`define UEIT_F_TRE   3
`define UEIT_F_BSY   4
`define UEIT_F_STL   5
`define UEIT_D_RUN   0
`define UEIT_D_TRUNC 1
`define UEIT_D_BEIE  2
`define UEIT_D_SPE   3
`define UEIT_D_TEIE  4
`define UEIT_D_LEN   31:16
`define UEIT_S_BEND  1
`define UEIT_S_TEND  2
`define UEIT_PID_D0  2'h0
`endif

//--- dv/ueit_props.sv
// port checker for the endpoint block
`timescale 1ns/1ps
module ueit_props (
	input wire        clk_i,
	input wire        rst_i,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_we_i,
	input wire [7:0]  wb_adr_i,
	input wire [3:0]  wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire        wb_ack_o,
	input wire        in_tok_i,
	input wire        rx_pkt_i,
	input wire        tx_resp_o,
	input wire [1:0]  tx_pid_o,
	input wire        tx_zlp_o,
	input wire        stall_o,
	input wire        rx_ack_o,
	input wire        rx_nak_o,
	input wire        ep_irq_o,
	input wire        dma_irq_o
);
	logic       iso_q;
	logic [5:0] ien_q;
	logic [1:0] dirq_q;
	wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// shadow of iso mode and the enables, updated at the edge the slave takes the write
	always @(posedge clk_i)
		if (rst_i)
			{iso_q, ien_q, dirq_q} <= 9'h0;
		else if (wr)
		begin
			if (wb_adr_i == 8'h00) iso_q <= wb_dat_i[4];
			if (wb_adr_i == 8'h04) ien_q <= wb_dat_i[5:0];
			if (wb_adr_i == 8'h10) dirq_q <= {wb_dat_i[4], wb_dat_i[2]};
		end
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence s_ans; wb_ack_o ##1 !wb_ack_o; endsequence
	property p_ack; s_take |=> s_ans; endproperty
	a_ack: assert property (p_ack) else $error("ack not one cycle");
	property p_nostall; in_tok_i && iso_q |=> !stall_o; endproperty
	a_nostall: assert property (p_nostall) else $error("iso stall");
	property p_resp; tx_resp_o |-> $past(in_tok_i); endproperty
	a_resp: assert property (p_resp) else $error("reply w/o token");
	property p_pid; tx_resp_o |-> tx_pid_o != 2'h3; endproperty
	a_pid: assert property (p_pid) else $error("bad pid");
	property p_zlp; tx_zlp_o |-> tx_resp_o && !stall_o; endproperty
	a_zlp: assert property (p_zlp) else $error("stray zlp");
	property p_rx;
		rx_pkt_i |=> $onehot({rx_ack_o, rx_nak_o, stall_o});
	endproperty
	a_rx: assert property (p_rx) else $error("out not answered");
	// the level follows the enables written at the previous edge
	property p_irq; ien_q == 6'h0 |-> !ep_irq_o; endproperty
	a_irq: assert property (p_irq) else $error("masked irq");
	property p_dirq; dirq_q == 2'h0 |-> !dma_irq_o; endproperty
	a_dirq: assert property (p_dirq) else $error("masked dma irq");
endmodule // ueit_props
bind ueit_top ueit_props chk_u (.*);

//--- dv/ueit_host.sv
// usb host model: microframe, token and out packet pulses
`timescale 1ns/1ps
module ueit_host (
	input  wire         clk_i, // clock
	output logic        sof_o, // microframe start
	output logic        tok_o, // in token
	output logic        pkt_o, // out packet
	output logic [10:0] len_o  // packet length
);
	initial
	begin
		{sof_o, tok_o, pkt_o} = 3'h0;
		len_o = 11'h7ff;
	end
	// k: 0 sof, 1 token, 2 out packet; one cycle pulse
	task automatic pulse(input int k, input logic [10:0] n);
	begin
		@(posedge clk_i);
		sof_o <= k == 0;
		tok_o <= k == 1;
		pkt_o <= k == 2;
		if (k == 2) len_o <= n;
		@(posedge clk_i);
		{sof_o, tok_o, pkt_o} <= 3'h0;
		// length is stale once the packet is gone: show its inverse
		if (k == 2) len_o <= ~n;
	end
	endtask
endmodule // ueit_host

//--- dv/tb_top.sv
// self-checking bench for the endpoint block
`timescale 1ns/1ps
module tb_top;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o, q, seed = 32'h10a4;
	logic        wb_ack_o, sof_i, in_tok_i, rx_pkt_i, tx_resp_o, tx_zlp_o;
	logic        stall_o, rx_ack_o, rx_nak_o, ep_irq_o, dma_irq_o, en;
	logic [10:0] rx_len_i;
	logic [1:0]  tx_pid_o;
	logic [2:0]  got[$], exq[$];
	int error_cnt = 0, check_count = 0, cyc_n = 0, ack_n = 0, nak_n = 0;
	int i, nb, bk, av, tk, sent, p, z0, ife, flu, tre, stl_n;
	ueit_top dut_u (.*);
	ueit_host host_u (.clk_i(clk_i), .sof_o(sof_i), .tok_o(in_tok_i),
		.pkt_o(rx_pkt_i), .len_o(rx_len_i));
	initial forever #5 clk_i = ~clk_i;
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic final_report;
	begin
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
	begin
		check_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input [31:0] d);
	begin
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, w, 4'hf};
		wb_adr_i <= a;
		wb_dat_i <= d;
		// only wb_ack_o or the bench timeout ends this wait
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	end
	endtask
	task automatic rd(input logic [7:0] a, input [31:0] m, input [31:0] e);
	begin
		wb(1'b0, a, 32'h0);
		chk(q & m, e);
	end
	endtask
	always @(posedge clk_i)
	begin
		if (tx_resp_o === 1'b1) got.push_back({tx_pid_o, tx_zlp_o});
		if (rx_ack_o === 1'b1) ack_n++;
		if (rx_nak_o === 1'b1) nak_n++;
		if (stall_o === 1'b1) stl_n++;
		if (++cyc_n == 30000)
		begin
			error_cnt++;
			final_report;
		end
	end
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		bk = 0;
		for (i = 0; i < 12; i++)
		begin
			seed = xs(seed);
			nb = seed[1:0] % 3 + 1;
			en = seed[2];
			// random forced stall must be ignored on iso
			wb(1'b1, 8'h00, 32'h0200_0010 | nb | (seed[3] << 6));
			wb(1'b1, 8'h04, {30'h0, en, 1'b0});
			repeat (seed[5:4] % (4 - bk)) wb(1'b1, 8'h0c, 32'h1);
			av = bk + (seed[5:4] % (4 - bk));
			bk = av;
			{tk, sent, z0, ife} = 0;
			repeat (seed[7:6])
			begin
				host_u.pulse(1, 11'h0);
				if (tk < nb)
				begin
					p = (bk == 0 && tk == 0) ? 0 : nb - 1 - tk;
					if (bk > 0 || nb > 1) exq.push_back(3'(p * 2 + (bk == 0)));
					ife |= bk == 0;
					z0 |= bk == 0 && tk == 0;
					sent += bk > 0;
					bk -= bk > 0;
					tk++;
				end
			end
			host_u.pulse(0, 11'h0);
			flu = tk > 0 && !z0 && bk > 0 && nb > tk;
			if (flu) bk -= (bk < nb - tk) ? bk : nb - tk;
			tre = sent > 0 && av < nb;
			repeat (2) @(posedge clk_i);
			chk(got.size(), exq.size());
			while (got.size() > 0 && exq.size() > 0)
				chk(got.pop_front(), exq.pop_front());
			got.delete();
			exq.delete();
			rd(8'h08, 32'h32e, (bk << 8) | (tre << 3) | (flu << 2) | (ife << 1));
			chk(ep_irq_o, ife & en);
			wb(1'b1, 8'h08, 32'h3f);
		end
		// non-iso in: forced stall, then data0 per bank, then silence
		wb(1'b1, 8'h00, 32'h0200_0041);
		host_u.pulse(1, 11'h0);
		wb(1'b1, 8'h00, 32'h0200_0001);
		wb(1'b1, 8'h0c, 32'h1);
		bk += bk < 3;
		repeat (bk + 1) host_u.pulse(1, 11'h0);
		repeat (2) @(posedge clk_i);
		chk(got.size(), bk);
		while (got.size() > 0)
			chk(got.pop_front(), 3'h0);
		rd(8'h08, 32'h320, 32'h20);
		wb(1'b1, 8'h08, 32'h3f);
		wb(1'b1, 8'h00, 32'h0200_0005);
		wb(1'b1, 8'h04, 32'h1);
		host_u.pulse(2, 11'h0);
		repeat (2) @(posedge clk_i);
		rd(8'h08, 32'h07ff_0c01, 32'h401);
		chk(ep_irq_o, 1'b1);
		wb(1'b1, 8'h08, 32'h1);
		rd(8'h08, 32'hc01, 32'h0);
		wb(1'b1, 8'h00, 32'h0200_0029);
		wb(1'b1, 8'h04, 32'h10);
		repeat (3) host_u.pulse(2, 11'h4);
		repeat (2) @(posedge clk_i);
		rd(8'h08, 32'h07ff_0c10, 32'h0004_0810);
		chk(ep_irq_o, 1'b1);
		wb(1'b1, 8'h08, 32'h3f);
		wb(1'b1, 8'h10, 32'h0008_0015);
		repeat (8) @(posedge clk_i);
		rd(8'h14, 32'hffff_0007, 32'h2);
		chk(dma_irq_o, 1'b1);
		rd(8'h08, 32'hc00, 32'h0);
		wb(1'b1, 8'h14, 32'h6);
		wb(1'b1, 8'h10, 32'h0010_0019);
		host_u.pulse(2, 11'h6);
		repeat (8) @(posedge clk_i);
		rd(8'h14, 32'hffff_0007, 32'h000a_0004);
		chk(dma_irq_o, 1'b1);
		wb(1'b1, 8'h14, 32'h6);
		wb(1'b1, 8'h10, 32'h0003_0003);
		host_u.pulse(2, 11'h6);
		repeat (8) @(posedge clk_i);
		rd(8'h14, 32'hffff_0007, 32'h2);
		chk(dma_irq_o, 1'b0);
		rd(8'h08, 32'hc00, 32'h0);
		host_u.pulse(2, 11'h4);
		repeat (2) @(posedge clk_i);
		rd(8'h08, 32'h07ff_0c01, 32'h0004_0401);
		host_u.pulse(2, 11'h0);
		repeat (2) @(posedge clk_i);
		rd(8'h08, 32'h07ff_0c01, 32'h400);
		rd(8'h18, 32'hffff_ffff, 32'h0);
		rd(8'h08, 32'hc00, 32'h0);
		rd(8'h40, 32'hffff_ffff, 32'h0);
		chk(ack_n, 7);
		chk(nak_n, 1);
		chk(stl_n, 1);
		final_report;
	end
endmodule // tb_top
